/* File: shared/cpwm_pkg.sv */
// Package of register map, field layout and reset values for the PWM unit
package cpwm_pkg;
  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] OFS_DUTY_WRITE  = 8'h00; // Duty upper write byte
  localparam logic [7:0] OFS_DUTY_ACTIVE = 8'h01; // Active duty byte
  localparam logic [7:0] OFS_UNIT_CTRL   = 8'h02; // Unit control
  localparam logic [7:0] OFS_PERIOD      = 8'h03; // Period limit
  localparam logic [7:0] OFS_TIMEBASE    = 8'h04; // Timebase counter
  localparam logic [7:0] OFS_TB_CTRL     = 8'h05; // Timebase control
  localparam logic [7:0] OFS_PORTC_DIR   = 8'h06; // Port C direction
  // ********************************
  // Field positions and codes
  // ********************************
  localparam int          PIN_DIR_BIT    = 2;      // Direction bit of pin
  localparam int          TB_ON_BIT      = 2;      // Timebase run bit
  localparam logic [1:0]  PWM_MODE_CODE  = 2'h3;   // Mode bits 3:2 = 11
  localparam logic [1:0]  PHASE_LAST     = 2'h3;   // Last quarter phase
  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] RST_UNIT_CTRL  = 8'h00;
  localparam logic [7:0] RST_DUTY       = 8'h00;
  localparam logic [7:0] RST_PERIOD     = 8'hff;
  localparam logic [7:0] RST_TB_CTRL    = 8'h00;
  localparam logic [7:0] RST_PORTC_DIR  = 8'hff;
  // ********************************
  // Carriers
  // ********************************
  // Register port request
  typedef struct packed {
    logic [7:0] addr;    // Register offset
    logic [7:0] wdata;   // Write data
    logic       wr;      // Write strobe
    logic       rd;      // Read strobe
  } cpwm_bus_req_t;
  // Unit control layout
  typedef struct packed {
    logic [1:0] rsvd;     // Read as zero
    logic [1:0] dutyLow;  // Two low duty bits
    logic [3:0] mode;     // Mode select
  } cpwm_ctrl_t;
endpackage : cpwm_pkg

/* File: rtl/cpwm_timebase.sv */
// Timebase: prescaler, quarter phase and 8-bit counter with period rollover
`timescale 1ns/1ps
`default_nettype none
module cpwm_timebase
  import cpwm_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [1:0]       prescaleSel,
  input  wire logic [CNT_W-1:0] periodLimit,
  input  wire logic             loadEn,
  input  wire logic [CNT_W-1:0] loadValue,
  output logic      [CNT_W-1:0] count,
  output logic      [1:0]       phase,
  output logic                  rollover
);
  // ********************************
  // Elaboration check
  // ********************************
  if (CNT_W < 2 || CNT_W > 16) begin : g_chk
    $error("cpwm_timebase: CNT_W out of range");
  end

  logic [3:0] psCnt;   // Prescale sub-counter
  logic [3:0] psLimit; // Prescale factor minus one
  logic       tick;    // One prescaled oscillator period done

  // Factor 1, 4 or 16
  always_comb begin
    case (prescaleSel)
      2'h0:    psLimit = 4'h0;
      2'h1:    psLimit = 4'h3;
      default: psLimit = 4'hf;
    endcase
  end

  assign tick = enable && (psCnt >= psLimit);
  // Counter equal to limit at end of its last quarter
  assign rollover = tick && (phase == PHASE_LAST) && (count == periodLimit);

  // Prescaler and quarter phase
  always_ff @(posedge clock) begin
    if (rst || loadEn) begin
      psCnt <= 4'h0;
      phase <= 2'h0;
    end else if (tick) begin
      psCnt <= 4'h0;
      phase <= phase + 2'h1;
    end else if (enable) begin
      psCnt <= psCnt + 4'h1;
    end
  end

  // Counter advances each four prescaled periods
  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else if (loadEn) begin
      count <= loadValue;
    end else if (rollover) begin
      count <= '0;
    end else if (tick && phase == PHASE_LAST) begin
      count <= count + 1'b1;
    end
  end
endmodule : cpwm_timebase
`default_nettype wire

/* File: rtl/cpwm_generator.sv */
// PWM mode generator: register port, double-buffered duty and output pin
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cpwm_generator
  import cpwm_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire cpwm_bus_req_t busReq,
  output logic [7:0]         readData,
  output logic               pwmOutPin,
  output logic               pwmOutPinOe
);
  // ********************************
  // Elaboration check
  // ********************************
  if (DATA_W != 8) begin : g_chk
    $error("cpwm_generator: only 8-bit data supported");
  end

  // ********************************
  // Registers
  // ********************************
  logic [7:0] dutyUpperWriteByte; // Software duty byte
  logic [7:0] dutyActiveByte;     // Active duty byte
  logic [1:0] dutyActiveLow;      // Hidden two-bit latch
  cpwm_ctrl_t unitControl;        // Control register
  logic [7:0] periodLimit;        // Period register
  logic [7:0] timebaseControl;    // Run and prescale
  logic [7:0] portcDirection;     // Port C direction
  logic       pwmLatch;           // PWM output latch

  // ********************************
  // Decode
  // ********************************
  logic       wrDuty;       // Write to duty byte
  logic       wrCtrl;       // Write to control
  logic       wrPeriod;     // Write to period
  logic       wrTimebase;   // Write to counter
  logic       wrTbCtrl;     // Write to timebase control
  logic       wrPortDir;    // Write to direction
  logic       wrActive;     // Write to active byte
  logic       ctrlZeroWr;   // Whole control written zero
  logic       pwmMode;      // Unit in PWM mode
  logic [9:0] nextDuty;     // Buffered ten-bit duty
  logic [9:0] activeDuty;   // Active ten-bit duty
  logic [9:0] fineCount;    // Counter with phase bits
  logic [7:0] tbCount;      // Timebase counter
  logic [1:0] tbPhase;      // Quarter phase
  logic       rollover;     // Period match pulse
  logic       dutyMatch;    // Extended count meets active duty
  logic [7:0] next_readData;// Read mux result

  // Address strobes
  assign wrDuty     = busReq.wr && busReq.addr == OFS_DUTY_WRITE;
  assign wrCtrl     = busReq.wr && busReq.addr == OFS_UNIT_CTRL;
  assign wrPeriod   = busReq.wr && busReq.addr == OFS_PERIOD;
  assign wrTimebase = busReq.wr && busReq.addr == OFS_TIMEBASE;
  assign wrTbCtrl   = busReq.wr && busReq.addr == OFS_TB_CTRL;
  assign wrPortDir  = busReq.wr && busReq.addr == OFS_PORTC_DIR;
  assign wrActive   = busReq.wr && busReq.addr == OFS_DUTY_ACTIVE;
  assign ctrlZeroWr = wrCtrl && busReq.wdata == 8'h00;

  // Mode and duty views
  assign pwmMode    = unitControl.mode[3:2] == PWM_MODE_CODE;
  assign nextDuty   = {dutyUpperWriteByte, unitControl.dutyLow};
  assign activeDuty = {dutyActiveByte, dutyActiveLow};
  assign fineCount  = {tbCount, tbPhase};
  assign dutyMatch  = fineCount == activeDuty;

  // ********************************
  // Timebase
  // ********************************
  // Prescaled counter; no postscaler in this path
  cpwm_timebase #(
    .CNT_W (8)
  ) u_timebase (
    .clock       (clock),
    .rst         (rst),
    .enable      (timebaseControl[TB_ON_BIT]),
    .prescaleSel (timebaseControl[1:0]),
    .periodLimit (periodLimit),
    .loadEn      (wrTimebase),
    .loadValue   (busReq.wdata),
    .count       (tbCount),
    .phase       (tbPhase),
    .rollover    (rollover)
  );

  // ********************************
  // Software registers
  // ********************************
  // Duty write byte, accepted any time
  always_ff @(posedge clock) begin
    if (rst) begin
      dutyUpperWriteByte <= RST_DUTY;
    end else if (wrDuty) begin
      dutyUpperWriteByte <= busReq.wdata;
    end
  end

  // Control register, top bits read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      unitControl <= RST_UNIT_CTRL;
    end else if (wrCtrl) begin
      unitControl <= {2'h0, busReq.wdata[5:0]};
    end
  end

  // Period limit
  always_ff @(posedge clock) begin
    if (rst) begin
      periodLimit <= RST_PERIOD;
    end else if (wrPeriod) begin
      periodLimit <= busReq.wdata;
    end
  end

  // Timebase control: bit 2 run, bits 1:0 prescale
  always_ff @(posedge clock) begin
    if (rst) begin
      timebaseControl <= RST_TB_CTRL;
    end else if (wrTbCtrl) begin
      timebaseControl <= {5'h00, busReq.wdata[2:0]};
    end
  end

  // Port C direction, all inputs after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      portcDirection <= RST_PORTC_DIR;
    end else if (wrPortDir) begin
      portcDirection <= busReq.wdata;
    end
  end

  // ********************************
  // Double buffer
  // ********************************
  // Copy at rollover only; port writes never reach it
  always_ff @(posedge clock) begin
    if (rst) begin
      dutyActiveByte <= RST_DUTY;
      dutyActiveLow  <= 2'h0;
    end else if (rollover && pwmMode) begin
      dutyActiveByte <= nextDuty[9:2];
      dutyActiveLow  <= nextDuty[1:0];
    end
  end

  // ********************************
  // Output latch
  // ********************************
  // Zero control wins, then rollover set, then match clear
  always_ff @(posedge clock) begin
    if (rst) begin
      pwmLatch <= 1'b0;
    end else if (ctrlZeroWr) begin
      pwmLatch <= 1'b0;
    end else if (!pwmMode) begin
      pwmLatch <= 1'b0;
    end else if (rollover) begin
      pwmLatch <= nextDuty != 10'h000;
    end else if (dutyMatch) begin
      pwmLatch <= 1'b0;
    end
  end

  // Pin level and enable, registered; the pin drops in the cycle the
  // extended count meets duty, so high time is duty ticks exactly,
  // even when that match shares its cycle with the rollover
  always_ff @(posedge clock) begin
    if (rst) begin
      pwmOutPin   <= 1'b0;
      pwmOutPinOe <= 1'b0;
    end else begin
      pwmOutPin   <= pwmLatch && !dutyMatch;
      pwmOutPinOe <= !portcDirection[PIN_DIR_BIT];
    end
  end

  // ********************************
  // Read port
  // ********************************
  // Read mux; unmapped offsets read zero
  always_comb begin
    next_readData = 8'h00;
    if (busReq.rd) begin
      case (busReq.addr)
        OFS_DUTY_WRITE:  next_readData = dutyUpperWriteByte;
        OFS_DUTY_ACTIVE: next_readData = dutyActiveByte;
        OFS_UNIT_CTRL:   next_readData = unitControl;
        OFS_PERIOD:      next_readData = periodLimit;
        OFS_TIMEBASE:    next_readData = tbCount;
        OFS_TB_CTRL:     next_readData = timebaseControl;
        OFS_PORTC_DIR:   next_readData = portcDirection;
        default:         next_readData = 8'h00;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      readData <= 8'h00;
    end else begin
      readData <= next_readData;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Zero control forces the latch low
  property p_ctrl_zero;
    ctrlZeroWr |=> !pwmLatch;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("latch not low after zero control");

  // Rollover with nonzero duty sets pin
  property p_roll_set;
    rollover && pwmMode && !wrCtrl && nextDuty != 10'h000
      |=> pwmLatch ##1 pwmOutPin;
  endproperty
  a_roll_set: assert property (p_roll_set)
    else $error("pin not set at rollover");

  // Zero duty keeps pin low
  property p_zero_duty;
    rollover && nextDuty == 10'h000 |=> !pwmLatch;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("pin set with zero duty");

  // Duty copied at rollover
  property p_copy;
    rollover && pwmMode |=> activeDuty == $past(nextDuty);
  endproperty
  a_copy: assert property (p_copy)
    else $error("duty not latched at rollover");

  // Active duty steady between rollovers
  property p_hold;
    !rollover |=> $stable(activeDuty);
  endproperty
  a_hold: assert property (p_hold)
    else $error("active duty changed mid period");

  // Writes to active byte ignored
  property p_active_ro;
    wrActive && !rollover |=> $stable(dutyActiveByte);
  endproperty
  a_active_ro: assert property (p_active_ro)
    else $error("active byte took a write");

  // Match clears the latch
  property p_match;
    pwmMode && !rollover && !wrCtrl && fineCount == activeDuty
      |=> !pwmLatch;
  endproperty
  a_match: assert property (p_match)
    else $error("latch not cleared at match");

  // Counter and phase restart after rollover
  property p_wrap;
    rollover && !wrTimebase |=> tbCount == 8'h00 && tbPhase == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not restart");

  // Pin enable follows direction bit
  property p_dir;
    pwmOutPinOe == !$past(portcDirection[PIN_DIR_BIT]);
  endproperty
  a_dir: assert property (p_dir)
    else $error("pin enable wrong");

  // Latch only rises at rollover
  property p_rise;
    $rose(pwmLatch) |-> $past(rollover);
  endproperty
  a_rise: assert property (p_rise)
    else $error("latch rose off rollover");

  // Pin rises only one cycle after a rollover set the latch
  property p_pin_rise;
    $rose(pwmOutPin) |-> $past(rollover, 2);
  endproperty
  a_pin_rise: assert property (p_pin_rise)
    else $error("pin rose off rollover");

  // Duty match cuts the pin at once and keeps it low
  property p_pin_cut;
    pwmLatch && !rollover && dutyMatch |=> !pwmOutPin ##1 !pwmOutPin;
  endproperty
  a_pin_cut: assert property (p_pin_cut)
    else $error("pin not cut at duty match");

  // Duty beyond the last extended count never clears the latch
  property p_full;
    pwmMode && pwmLatch && !rollover && !ctrlZeroWr && tbCount <= periodLimit
      && activeDuty > {periodLimit, PHASE_LAST} |=> pwmLatch;
  endproperty
  a_full: assert property (p_full)
    else $error("latch cleared with duty beyond period");

  // Zero control brings the pin itself low
  property p_zero_pin;
    ctrlZeroWr |=> ##1 !pwmOutPin;
  endproperty
  a_zero_pin: assert property (p_zero_pin)
    else $error("pin not low after zero control");

  // Active byte read returns the latched duty
  property p_read_active;
    busReq.rd && busReq.addr == OFS_DUTY_ACTIVE |=> readData == $past(dutyActiveByte);
  endproperty
  a_read_active: assert property (p_read_active)
    else $error("active byte read wrong");

  // Main scenarios
  c_roll_set:  cover property (rollover && pwmMode ##1 pwmLatch);
  c_match:     cover property (pwmLatch ##1 !pwmLatch && !$past(ctrlZeroWr));
  c_full_high: cover property (rollover && pwmMode && pwmLatch);
  c_zero_ctrl: cover property (pwmLatch && ctrlZeroWr);
  c_pin_cut:   cover property (pwmLatch && dutyMatch ##1 !pwmOutPin);
endmodule : cpwm_generator
`default_nettype wire

/* File: tb/cpwm_generator_tb_top.sv */
// Self-checking bench for the PWM mode generator
`timescale 1ns/1ps
`default_nettype none
module cpwm_generator_tb_top
  import cpwm_pkg::*;
;
  // ****************************
  // Signals and bookkeeping
  // ****************************
  logic          clock;       // System clock
  logic          rst;         // Synchronous reset
  cpwm_bus_req_t busReq;      // Register request
  logic [7:0]    readData;    // Read answer
  logic          pwmOutPin;   // PWM level
  logic          pwmOutPinOe; // Pin drive enable
  int            miscompares; // Mismatch count
  int            testsRun;    // Compare count
  int            seed;        // Random seed
  logic [7:0]    lastActive;  // Model of active duty byte
  logic [7:0]    rstTab [8];  // Model of reset values

  cpwm_generator i_cpwm_generator (
    .clock       (clock),
    .rst         (rst),
    .busReq      (busReq),
    .readData    (readData),
    .pwmOutPin   (pwmOutPin),
    .pwmOutPinOe (pwmOutPinOe)
  );

  // Free running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************
  // Compare and bus tasks
  // ****************************
  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch reg at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkReg

  task automatic chkTime(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch pin at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkTime

  // One-cycle write strobe
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
  endtask : wrReg

  // Read, answer in next cycle only
  task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    @(negedge clock);
    chkReg(readData, exp);
    @(negedge clock);
    chkReg(readData, 8'h00);
  endtask : rdReg

  // ****************************
  // One PWM configuration
  // ****************************
  task automatic runCase(input logic [9:0] duty, input logic [7:0] per, input logic [1:0] sel);
    int pre;
    int perExp;
    int dPre;
    int hi;
    int cnt;
    int lim;
    logic fell;
    logic prev;
    pre = (sel == 2'h0) ? 1 : ((sel == 2'h1) ? 4 : 16);
    perExp = (int'(per) + 1) * 4 * pre;
    dPre = int'(duty) * pre;
    lim = perExp + 8;
    wrReg(OFS_TB_CTRL, 8'h00);
    wrReg(OFS_UNIT_CTRL, 8'h00);
    wrReg(OFS_TIMEBASE, 8'h00);
    wrReg(OFS_PERIOD, per);
    wrReg(OFS_DUTY_WRITE, duty[9:2]);
    wrReg(OFS_DUTY_ACTIVE, ~duty[9:2]);
    wrReg(OFS_UNIT_CTRL, {2'b00, duty[1:0], PWM_MODE_CODE, 2'b00});
    rdReg(OFS_DUTY_ACTIVE, lastActive);
    wrReg(OFS_TB_CTRL, {5'h00, 1'b1, sel});
    hi = 0;
    cnt = 0;
    // Zero duty never raises the pin
    if (duty == 10'h000) begin
      repeat (2 * perExp + 16) begin
        @(negedge clock);
        if (pwmOutPin !== 1'b0) hi++;
      end
      chkTime(16'(hi), 16'h0000);
    end else begin
      // Wait for the rollover rise
      @(negedge clock);
      while (pwmOutPin !== 1'b1 && cnt < 2 * perExp + 16) begin
        @(negedge clock);
        cnt++;
      end
      fell = 1'b0;
      prev = 1'b1;
      cnt = 0;
      do begin
        if (pwmOutPin === 1'b0) fell = 1'b1;
        else if (!fell) hi++;
        prev = pwmOutPin;
        cnt++;
        @(negedge clock);
      end while (!(prev === 1'b0 && pwmOutPin === 1'b1) && cnt < lim);
      // Full period high when duty reaches period
      chkTime(16'(hi), 16'((dPre >= perExp) ? lim : dPre));
      chkTime(16'(cnt), 16'((dPre >= perExp) ? lim : perExp));
    end
    rdReg(OFS_DUTY_ACTIVE, duty[9:2]);
    lastActive = duty[9:2];
    wrReg(OFS_UNIT_CTRL, 8'h00);
    repeat (2) @(negedge clock);
    chkTime({15'h0000, pwmOutPin}, 16'h0000);
    $display("case done: duty %h period %h prescale %0d", duty, per, pre);
  endtask : runCase

  // ****************************
  // Verdict
  // ****************************
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Watchdog: eleven cases of at most a few thousand clocks each
  initial begin
    #600_000;
    miscompares++;
    end_of_test();
  end

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    logic [7:0] p;
    logic [1:0] s;
    miscompares = 0;
    testsRun = 0;
    seed = 36;
    lastActive = RST_DUTY;
    rstTab = '{RST_DUTY, RST_DUTY, RST_UNIT_CTRL, RST_PERIOD, 8'h00, RST_TB_CTRL,
               RST_PORTC_DIR, 8'h00};
    rst = 1'b1;
    busReq = '0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Reset values, unmapped place included
    for (int i = 0; i < 8; i++) rdReg(8'(i), rstTab[i]);
    chkTime({15'h0000, pwmOutPinOe}, 16'h0000);
    $display("reset values done");
    // Access kinds and reserved bits
    wrReg(OFS_DUTY_WRITE, 8'ha5);
    rdReg(OFS_DUTY_WRITE, 8'ha5);
    wrReg(OFS_UNIT_CTRL, 8'hff);
    rdReg(OFS_UNIT_CTRL, 8'h3f);
    wrReg(OFS_TB_CTRL, 8'hf8);
    rdReg(OFS_TB_CTRL, 8'h00);
    wrReg(OFS_TIMEBASE, 8'h5a);
    rdReg(OFS_TIMEBASE, 8'h5a);
    wrReg(OFS_PERIOD, 8'h3c);
    rdReg(OFS_PERIOD, 8'h3c);
    wrReg(8'h07, 8'hff);
    rdReg(8'h07, 8'h00);
    wrReg(OFS_PORTC_DIR, 8'hfb);
    // Enable lags the direction bit by one register
    repeat (2) @(negedge clock);
    chkTime({15'h0000, pwmOutPinOe}, 16'h0001);
    $display("register access done");
    // Boundary cases
    runCase(10'h000, 8'h03, 2'h0);
    runCase(10'h010, 8'h03, 2'h0);
    runCase(10'h3ff, 8'h03, 2'h1);
    runCase(10'h3ff, 8'hff, 2'h0);
    runCase(10'h001, 8'h00, 2'h2);
    // Random cases
    repeat (6) begin
      p = 8'($unsigned($random(seed)) % 16);
      s = 2'($unsigned($random(seed)) % 3);
      runCase(10'($unsigned($random(seed)) % (4 * (int'(p) + 1) - 1) + 1), p, s);
    end
    end_of_test();
  end
endmodule : cpwm_generator_tb_top
`default_nettype wire
